// ### inc/ecf_pkg.sv
// constants and types for the external code fetch bus controller
package ecf_pkg;
  localparam int ECF_ADDR_W = 16;
  localparam int ECF_DATA_W = 8;
  localparam int ECF_BYTE_W = 8;
  // one bus cycle is six cpu clocks
  localparam int ECF_CPU_CLKS_PER_CYCLE = 6;
  // oscillator periods per cpu clock: 2 standard, 1 double speed
  localparam logic [1:0] ECF_OSC_PER_CPU_STD = 2'h2;
  localparam logic [1:0] ECF_OSC_PER_CPU_DBL = 2'h1;
  // cpu-clock phase numbers within a bus cycle
  localparam logic [2:0] ECF_PH_ALE_ON = 3'h0;
  localparam logic [2:0] ECF_PH_ALE_OFF = 3'h2;
  localparam logic [2:0] ECF_PH_STROBE_ON = 3'h3;
  localparam logic [2:0] ECF_PH_LAST = 3'h5;
  localparam logic [ECF_BYTE_W-1:0] ECF_DATA_RST = 8'hFF;
  localparam logic [ECF_ADDR_W-1:0] ECF_ADDR_RST = 16'hFFFF;

  typedef enum logic [2:0] {
    ECF_IDLE = 3'b001,
    ECF_ADDR = 3'b010,
    ECF_READ = 3'b100
  } ecf_state_type;
endpackage : ecf_pkg

// ### rtl/ecf_osc_div.sv
// cpu clock tick generator from oscillator periods, standard or double speed
`timescale 1ns/100ps
module ecf_osc_div (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // mode
  input wire logic double_speed_mode,
  // tick out
  output logic cpu_tick
);
  import ecf_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] period;

  always_comb begin
    period = double_speed_mode ? ECF_OSC_PER_CPU_DBL : ECF_OSC_PER_CPU_STD;
    cpu_tick = (cnt_r >= period - 2'h1);
    cnt_nxt = cpu_tick ? 2'h0 : cnt_r + 2'h1;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : ecf_osc_div

// ### rtl/ecf_fetch_bus.sv
// external code fetch bus controller: multiplexed low port, high port, strobes
`timescale 1ns/100ps
module ecf_fetch_bus (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // mode
  input wire logic double_speed_mode,
  // core request
  input wire logic req_valid,
  input wire logic req_const_read,
  input wire logic req_internal,
  input wire logic [ecf_pkg::ECF_ADDR_W-1:0] req_addr,
  output logic req_ready,
  output logic rsp_valid,
  output logic [ecf_pkg::ECF_DATA_W-1:0] rsp_data,
  // external bus pins
  output logic address_latch_strobe,
  output logic program_store_strobe_n,
  output logic [ecf_pkg::ECF_BYTE_W-1:0] addr_high_lines,
  output logic [ecf_pkg::ECF_BYTE_W-1:0] low_port_out,
  output logic low_port_oe,
  input wire logic [ecf_pkg::ECF_BYTE_W-1:0] low_port_in
);
  import ecf_pkg::*;

  // bus sequencer
  ecf_state_type state_r;
  ecf_state_type state_nxt;
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic state_bad;
  // pin drivers
  logic ale_r;
  logic ale_nxt;
  logic store_n_r;
  logic store_n_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [ECF_BYTE_W-1:0] lo_out_r;
  logic [ECF_BYTE_W-1:0] lo_out_nxt;
  logic [ECF_BYTE_W-1:0] hi_r;
  logic [ECF_BYTE_W-1:0] hi_nxt;
  // answer to the core
  logic [ECF_DATA_W-1:0] data_r;
  logic [ECF_DATA_W-1:0] data_nxt;
  logic rsp_r;
  logic rsp_nxt;
  // low port input synchroniser
  logic [ECF_BYTE_W-1:0] din_meta_r;
  logic [ECF_BYTE_W-1:0] din_meta_nxt;
  logic [ECF_BYTE_W-1:0] din_sync_r;
  logic [ECF_BYTE_W-1:0] din_sync_nxt;
  // shared decodes
  logic cpu_tick;
  logic take;
  logic goes_out;
  logic start_ext;
  logic answer_int;
  logic [2:0] phase_inc;
  logic at_ale_off;
  logic at_strobe_on;
  logic at_last;

  ecf_osc_div u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .double_speed_mode(double_speed_mode),
    .cpu_tick(cpu_tick)
  );

  // pin data crosses in from the outside world; only the second stage is read
  always_comb begin
    din_meta_nxt = low_port_in;
    din_sync_nxt = din_meta_r;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      din_meta_r <= ECF_DATA_RST;
      din_sync_r <= ECF_DATA_RST;
    end else begin
      din_meta_r <= din_meta_nxt;
      din_sync_r <= din_sync_nxt;
    end
  end

  // requests are taken only at a cpu-clock boundary while idle; ready never
  // looks at the request itself, at the price of one idle cpu clock between
  // back-to-back cycles
  assign req_ready = (state_r == ECF_IDLE) && cpu_tick;
  assign take = req_valid && req_ready;
  // internal constant reads never reach the pins; internal prefetch at the
  // top location does run an external cycle, so software must avoid it
  assign goes_out = !(req_internal && req_const_read);
  assign start_ext = take && goes_out;
  assign answer_int = take && !goes_out;

  // phase decodes, each one valid only on a cpu-clock tick
  assign phase_inc = phase_r + 3'h1;
  assign at_ale_off = cpu_tick && (state_r == ECF_ADDR) && (phase_inc == ECF_PH_ALE_OFF);
  assign at_strobe_on = cpu_tick && (state_r == ECF_ADDR) && (phase_inc == ECF_PH_STROBE_ON);
  assign at_last = cpu_tick && (state_r == ECF_READ) && (phase_r == ECF_PH_LAST);

  // bus sequencer: six cpu-clock phases per external cycle
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    state_bad = 1'h0;
    case (state_r)
      ECF_IDLE: begin
        if (start_ext) begin
          state_nxt = ECF_ADDR;
          phase_nxt = ECF_PH_ALE_ON;
        end
      end
      ECF_ADDR: begin
        if (cpu_tick) begin
          phase_nxt = phase_inc;
        end
        if (at_strobe_on) begin
          state_nxt = ECF_READ;
        end
      end
      ECF_READ: begin
        if (cpu_tick) begin
          phase_nxt = phase_inc;
        end
        if (at_last) begin
          phase_nxt = ECF_PH_ALE_ON;
          state_nxt = ECF_IDLE;
        end
      end
      default: begin
        // a corrupted state code falls back to idle with the bus parked
        state_bad = 1'h1;
        state_nxt = ECF_IDLE;
        phase_nxt = ECF_PH_ALE_ON;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ECF_IDLE;
      phase_r <= ECF_PH_ALE_ON;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // pin drivers: every pin comes straight from a flip-flop, so no glitch
  // reaches the external latch or memory
  always_comb begin
    ale_nxt = ale_r;
    store_n_nxt = store_n_r;
    oe_nxt = oe_r;
    lo_out_nxt = lo_out_r;
    hi_nxt = hi_r;
    if (start_ext) begin
      hi_nxt = req_addr[ECF_ADDR_W-1 -: ECF_BYTE_W];
      lo_out_nxt = req_addr[ECF_BYTE_W-1:0];
      oe_nxt = 1'h1;
      ale_nxt = 1'h1;
    end
    if (at_ale_off) begin
      // memory latches the low byte on this falling edge
      ale_nxt = 1'h0;
    end
    if (at_strobe_on) begin
      // port released on the same edge the strobe falls; the memory only
      // drives once it sees the strobe low, so the two never fight
      oe_nxt = 1'h0;
      store_n_nxt = 1'h0;
    end
    if (at_last || state_bad) begin
      store_n_nxt = 1'h1;
    end
    if (state_bad) begin
      ale_nxt = 1'h0;
      oe_nxt = 1'h0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_r <= 1'h0;
      store_n_r <= 1'h1;
      oe_r <= 1'h0;
      lo_out_r <= ECF_DATA_RST;
      hi_r <= ECF_DATA_RST;
    end else begin
      ale_r <= ale_nxt;
      store_n_r <= store_n_nxt;
      oe_r <= oe_nxt;
      lo_out_r <= lo_out_nxt;
      hi_r <= hi_nxt;
    end
  end

  // answer to the core: one pulse per request, data held until the next
  always_comb begin
    data_nxt = data_r;
    rsp_nxt = 1'h0;
    if (answer_int) begin
      // internal constant read answers without bus activity
      data_nxt = ECF_DATA_RST;
      rsp_nxt = 1'h1;
    end
    if (at_last) begin
      // data sampled before the strobe rises, memory still driving
      data_nxt = din_sync_r;
      rsp_nxt = 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r <= ECF_DATA_RST;
      rsp_r <= 1'h0;
    end else begin
      data_r <= data_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign address_latch_strobe = ale_r;
  assign program_store_strobe_n = store_n_r;
  assign addr_high_lines = hi_r;
  assign low_port_out = lo_out_r;
  assign low_port_oe = oe_r;
  assign rsp_valid = rsp_r;
  assign rsp_data = data_r;
endmodule : ecf_fetch_bus

// ### bench/ecf_fetch_bus_asserts.sv
// checker for the external code fetch bus pins
`timescale 1ns/100ps
module ecf_fetch_bus_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request side
  input wire logic double_speed_mode,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_const_read,
  input wire logic req_internal,
  input wire logic [15:0] req_addr,
  input wire logic rsp_valid,
  // bus pins
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe_n,
  input wire logic [7:0] addr_high_lines,
  input wire logic [7:0] low_port_out,
  input wire logic low_port_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic t = req_valid && req_ready && !(req_internal && req_const_read);
  wire logic q = req_valid && req_ready && req_internal && req_const_read;
  wire logic f = t && double_speed_mode;
  wire logic s = t && !double_speed_mode;
  chk_high_addr: assert property (t |=> addr_high_lines == $past(req_addr[15:8]))
    else $error("bad high byte");
  chk_low_addr: assert property (t |=> low_port_oe && low_port_out == $past(req_addr[7:0]))
    else $error("bad low byte");
  chk_bus_turn: assert property (!program_store_strobe_n |-> !low_port_oe)
    else $error("low port driven in read");
  chk_strobe_len: assert property (f |=> address_latch_strobe [*2] ##1 !address_latch_strobe)
    else $error("latch strobe timing");
  chk_store_window: assert property (
    f |-> ##4 !program_store_strobe_n [*3] ##1 program_store_strobe_n)
    else $error("store strobe timing");
  chk_latch_std: assert property (
    s |=> address_latch_strobe [*4] ##1 !address_latch_strobe)
    else $error("standard latch strobe timing");
  chk_store_std: assert property (
    s |-> ##7 !program_store_strobe_n [*6] ##1 program_store_strobe_n)
    else $error("standard store strobe timing");
  chk_cycle_fast: assert property (f |-> ##7 rsp_valid)
    else $error("fast cycle length");
  chk_cycle_std: assert property (t && !double_speed_mode |-> ##13 rsp_valid)
    else $error("standard cycle length");
  chk_const_quiet: assert property (
    q |=> rsp_valid && program_store_strobe_n && !low_port_oe && !address_latch_strobe &&
    $stable(addr_high_lines) && $stable(low_port_out))
    else $error("ports moved on internal read");
  cover property (f);
  cover property (q);
  cover property (t && !double_speed_mode);
endmodule : ecf_fetch_bus_asserts
bind ecf_fetch_bus ecf_fetch_bus_asserts ecf_fetch_bus_asserts_inst (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .double_speed_mode(double_speed_mode),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req_const_read(req_const_read),
  .req_internal(req_internal),
  .req_addr(req_addr),
  .rsp_valid(rsp_valid),
  .address_latch_strobe(address_latch_strobe),
  .program_store_strobe_n(program_store_strobe_n),
  .addr_high_lines(addr_high_lines),
  .low_port_out(low_port_out),
  .low_port_oe(low_port_oe)
);

// ### bench/ecf_mem_model.sv
// external program memory with address latch on the low port
`timescale 1ns/100ps
module ecf_mem_model (
  // bus from the device
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe_n,
  input wire logic [7:0] addr_high_lines,
  input wire logic [7:0] low_port_out,
  input wire logic low_port_oe,
  // resolved low port level
  output logic [7:0] low_port_in
);
  logic [7:0] lat_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  wire logic [7:0] code = lat_r ^ addr_high_lines ^ 8'h5A;
  always @(negedge address_latch_strobe) lat_r = low_port_out;
  always @(posedge program_store_strobe_n) last_r = code;
  // released lines show the inverse so a late sample cannot match by luck
  assign low_port_in = low_port_oe ? low_port_out : (!program_store_strobe_n ? code : ~last_r);
endmodule : ecf_mem_model

// ### bench/external_code_fetch_bus_test.sv
// self-checking bench for the external code fetch bus controller
`timescale 1ns/100ps
module external_code_fetch_bus_test;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic double_speed_mode = 1'h1;
  logic req_valid = 1'h0;
  logic req_const_read = 1'h0;
  logic req_internal = 1'h0;
  logic [15:0] req_addr = 16'h0000;
  logic req_ready, rsp_valid, address_latch_strobe, program_store_strobe_n, low_port_oe;
  logic [7:0] rsp_data, addr_high_lines, low_port_out, low_port_in;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  ecf_fetch_bus ecf_fetch_bus_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .double_speed_mode(double_speed_mode),
    .req_valid(req_valid),
    .req_const_read(req_const_read),
    .req_internal(req_internal),
    .req_addr(req_addr),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .address_latch_strobe(address_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n),
    .addr_high_lines(addr_high_lines),
    .low_port_out(low_port_out),
    .low_port_oe(low_port_oe),
    .low_port_in(low_port_in)
  );
  ecf_mem_model ecf_mem_model_inst (
    .address_latch_strobe(address_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n),
    .addr_high_lines(addr_high_lines),
    .low_port_out(low_port_out),
    .low_port_oe(low_port_oe),
    .low_port_in(low_port_in)
  );
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done;
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      test_done();
    end
  end
  // k keeps the request raised so the next one follows back to back
  task automatic fetch(input logic [15:0] a, input logic c, input logic i, input logic k);
    int n;
    logic [7:0] e;
    logic bad;
    n = 0;
    e = (c && i) ? 8'hFF : a[7:0] ^ a[15:8] ^ 8'h5A;
    req_addr = a;
    req_const_read = c;
    req_internal = i;
    req_valid = 1'h1;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 40);
    num_checks++;
    bad = rsp_valid !== 1'h1 || rsp_data !== e;
    bad = bad || (!(c && i) && addr_high_lines !== a[15:8]);
    if (bad) begin
      fails++;
      $display("CHECK FAILED %0t fetch %h got %h", $time, a, rsp_data);
    end
    if (!k) begin
      req_valid = 1'h0;
      @(negedge core_clk);
    end
  endtask : fetch
  task automatic scn_fetch_fast;
    double_speed_mode = 1'h1;
    fetch(16'hA53C, 1'h0, 1'h0, 1'h0);
  endtask : scn_fetch_fast
  task automatic scn_const_std;
    double_speed_mode = 1'h0;
    fetch(16'h0FF0, 1'h1, 1'h0, 1'h0);
  endtask : scn_const_std
  task automatic scn_top_location;
    double_speed_mode = 1'h1;
    fetch(16'h7FFF, 1'h0, 1'h1, 1'h0);
    fetch(16'h7FFF, 1'h1, 1'h1, 1'h0);
  endtask : scn_top_location
  task automatic scn_back_to_back;
    fetch(16'h0000, 1'h0, 1'h0, 1'h1);
    fetch(16'hFF00, 1'h1, 1'h0, 1'h0);
  endtask : scn_back_to_back
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'h0;
    scn_fetch_fast();
    scn_const_std();
    scn_top_location();
    scn_back_to_back();
    test_done();
  end
endmodule : external_code_fetch_bus_test
